/* File: hw/spc_pkg.sv */
// constants, types and reset state of the serial port control block
package spc_pkg;
    // register addresses on the special-function bus
    localparam logic [7:0] SERIAL_PORT_CONTROL_ADDR = 8'h98;
    localparam logic [7:0] POWER_CONTROL_ADDR = 8'h87;
    localparam logic [7:0] SERIAL_DATA_ADDR = 8'h99;
    // serial_port_control field positions
    localparam int BIT_MODE_LOW_OR_FE = 7;
    localparam int BIT_MODE_HIGH = 6;
    localparam int BIT_MULTIPROC = 5;
    localparam int BIT_RX_ENABLE = 4;
    localparam int BIT_TX_NINTH = 3;
    localparam int BIT_RX_NINTH = 2;
    localparam int BIT_TX_DONE = 1;
    localparam int BIT_RX_DONE = 0;
    // power_control_register field positions
    localparam int BIT_BAUD_DOUBLE = 7;
    localparam int BIT_FE_VIEW = 6;
    // reset values
    localparam logic [7:0] SERIAL_PORT_CONTROL_RESET = 8'h00;
    localparam logic [1:0] POWER_CONTROL_RESET = 2'h0;
    // shift mode bit periods in clock (or timer overflow) units
    localparam logic [2:0] SHIFT_FAST_DIV = 3'h4;
    localparam logic [2:0] SHIFT_FAST_DIV_DBL = 3'h2;
    localparam logic [2:0] SHIFT_COMPAT_DIV = 3'h6;
    localparam logic [2:0] SHIFT_COMPAT_DIV_DBL = 3'h3;
    // oversampling and frame lengths
    localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
    localparam logic [3:0] SAMPLE_POINT = 4'h7;
    localparam logic [3:0] SHIFT_BITS = 4'h8;
    localparam logic [3:0] UART8_BITS = 4'hA;
    localparam logic [3:0] UART9_BITS = 4'hB;
    localparam logic [3:0] UART8_LAST_IDX = 4'h9;
    localparam logic [3:0] UART9_LAST_IDX = 4'hA;

    typedef enum logic [1:0] {
        SPC_SHIFT,
        SPC_UART8,
        SPC_UART9_FIXED,
        SPC_UART9_VAR
    } spc_mode_e;

    typedef struct packed {
        logic mode_select_low;
        logic mode_select_high;
        logic multiproc_or_clock_polarity;
        logic receive_enable;
        logic transmit_ninth_bit;
        logic receive_ninth_bit;
        logic transmit_done_flag;
        logic receive_done_flag;
        logic framing_error_flag;
        logic framing_error_view_select;
        logic baud_double_select;
        logic [7:0] rx_data;
        logic [7:0] rdata;
        logic irq;
        logic txd;
        logic rxd_out;
        logic rxd_oe;
        logic rxd_meta;
        logic rxd_sync;
        logic rxd_last;
        logic half;
        logic [2:0] phase;
        logic tx_busy;
        logic [3:0] tx_cnt;
        logic [3:0] tx_left;
        logic [10:0] tx_sh;
        logic rx_busy;
        logic [3:0] rx_cnt;
        logic [3:0] rx_idx;
        logic [8:0] rx_sh;
    } spc_state_s;

    localparam spc_state_s STATE_RESET = '{
        txd: 1'b1,
        rxd_out: 1'b1,
        rxd_meta: 1'b1,
        rxd_sync: 1'b1,
        rxd_last: 1'b1,
        tx_sh: 11'h7FF,
        default: '0
    };
endpackage

/* File: hw/spc_serial_port.sv */
// serial port control, status flags and shift engines
// Notes on behaviour
// R1: a frame whose stop bit is low sets the framing error flag.
// R2: framing error stays set over good frames; only software writing zero clears.
// R3: with view select set, control bit 7 reads and writes the framing flag.
// R4: framing flag is updated even while it is hidden from control bit 7.
// R5: control bit 7 is the low mode bit only while view select is zero.
// R6: mode bits pick shift register, 8-bit uart, or two 9-bit uarts.
// R7: mode 2 fixed /32 or /16; modes 1,3 timer; mode 0 /6,/3,/4,/2 or timer.
// R8: baud double select, power control bit 7, picks the fixed divider.
// R9: in mode 0 the polarity bit inverts the shift clock and its idle level.
// R10: in modes 2 and 3 the transmit ninth bit is sent as ninth data bit.
// R11: receive ninth bit holds ninth bit (modes 2,3) or stop bit (mode 1).
// R12: transmit done sets after 8th bit (mode 0) or as the stop bit starts; software clears it.
// R13: receive done sets after 8th bit (mode 0) or mid stop bit, filtered.
// R14: framing error view select is power control bit 6.
// R15: mode 0 receive starts on enable and done clear; others on start bit.
// R16: with polarity bit set, receive done needs ninth bit or valid stop bit.
// R17: control layout: bit7 mode low/fe, mode high, polarity, enable, tb, rb, done.
// R18: one interrupt request is high while either done flag is set.
`timescale 1ns/1ps
module spc_serial_port (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    input wire logic timer1_ovf_i,
    input wire logic timer2_ovf_i,
    input wire logic baud_from_timer2_i,
    input wire logic compat_mode_i,
    output logic txd_o,
    input wire logic rxd_i,
    output logic rxd_o,
    output logic rxd_oe_o,
    output logic serial_irq_o
);

    // decode of the two mode bits
    function automatic spc_pkg::spc_mode_e mode_of(input logic lo,
                                                   input logic hi);
        mode_of = spc_pkg::spc_mode_e'({lo, hi}); // R6
    endfunction

    // shift mode bit period
    function automatic logic [2:0] shift_period(input logic timer,
                                                input logic compat,
                                                input logic dbl);
        if (compat && !timer) begin
            shift_period = dbl ? spc_pkg::SHIFT_COMPAT_DIV_DBL
                               : spc_pkg::SHIFT_COMPAT_DIV; // R7 R8
        end else begin
            shift_period = dbl ? spc_pkg::SHIFT_FAST_DIV_DBL
                               : spc_pkg::SHIFT_FAST_DIV; // R7 R8
        end
    endfunction

    logic [1:0] rst_pipe;
    logic rst_n;
    spc_pkg::spc_state_s s;
    spc_pkg::spc_state_s n;

    // reset release through two flops
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    // state register
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            s <= spc_pkg::STATE_RESET;
        end else begin
            s <= n;
        end
    end

    // next state
    always_comb begin
        spc_pkg::spc_mode_e mode;
        logic [2:0] per;
        logic e;
        logic e0;
        logic s16;
        logic m0_end;
        logic wr_ctl;
        logic wr_pwr;
        logic wr_buf;
        logic bit_in;
        logic [3:0] last_idx;
        logic [8:0] sh;
        n = s;
        mode = mode_of(s.mode_select_low, s.mode_select_high);
        per = shift_period(s.transmit_ninth_bit, compat_mode_i,
                           s.baud_double_select);
        wr_ctl = sfr_wr_i && sfr_addr_i == spc_pkg::SERIAL_PORT_CONTROL_ADDR;
        wr_pwr = sfr_wr_i && sfr_addr_i == spc_pkg::POWER_CONTROL_ADDR;
        wr_buf = sfr_wr_i && sfr_addr_i == spc_pkg::SERIAL_DATA_ADDR;
        last_idx = (mode == spc_pkg::SPC_UART8) ? spc_pkg::UART8_LAST_IDX
                                                : spc_pkg::UART9_LAST_IDX;
        bit_in = 1'b0;
        sh = s.rx_sh;

        // receive pin synchroniser and edge history
        n.rxd_meta = rxd_i;
        n.rxd_sync = s.rxd_meta;
        n.rxd_last = s.rxd_sync;

        // 16x sample tick for the uart modes
        e = baud_from_timer2_i ? timer2_ovf_i : timer1_ovf_i; // R7
        if (mode == spc_pkg::SPC_UART9_FIXED) begin
            e = 1'b1; // R7
        end
        if (e) begin
            n.half = ~s.half;
        end
        s16 = e && (s.baud_double_select || s.half); // R8

        // shift mode bit timing
        e0 = s.transmit_ninth_bit ? timer1_ovf_i : 1'b1; // R7
        m0_end = e0 && (s.phase == per - 3'h1);
        if (mode == spc_pkg::SPC_SHIFT && (s.tx_busy || s.rx_busy) && e0) begin
            n.phase = m0_end ? 3'h0 : s.phase + 3'h1;
        end

        // software writes
        if (wr_ctl) begin
            if (s.framing_error_view_select) begin
                n.framing_error_flag =
                    sfr_wdata_i[spc_pkg::BIT_MODE_LOW_OR_FE]; // R2 R3
            end else begin
                n.mode_select_low =
                    sfr_wdata_i[spc_pkg::BIT_MODE_LOW_OR_FE]; // R5
            end
            n.mode_select_high = sfr_wdata_i[spc_pkg::BIT_MODE_HIGH]; // R17
            n.multiproc_or_clock_polarity = sfr_wdata_i[spc_pkg::BIT_MULTIPROC];
            n.receive_enable = sfr_wdata_i[spc_pkg::BIT_RX_ENABLE];
            n.transmit_ninth_bit = sfr_wdata_i[spc_pkg::BIT_TX_NINTH]; // R10
            n.receive_ninth_bit = sfr_wdata_i[spc_pkg::BIT_RX_NINTH];
            n.transmit_done_flag = sfr_wdata_i[spc_pkg::BIT_TX_DONE]; // R12
            n.receive_done_flag = sfr_wdata_i[spc_pkg::BIT_RX_DONE]; // R13
        end
        if (wr_pwr) begin
            n.baud_double_select = sfr_wdata_i[spc_pkg::BIT_BAUD_DOUBLE]; // R8
            n.framing_error_view_select =
                sfr_wdata_i[spc_pkg::BIT_FE_VIEW]; // R14
        end

        // transmit engine
        if (wr_buf) begin
            n.tx_busy = 1'b1;
            n.tx_cnt = 4'h0;
            n.phase = 3'h0;
            if (mode == spc_pkg::SPC_SHIFT) begin
                n.tx_sh = {3'h7, sfr_wdata_i};
                n.tx_left = spc_pkg::SHIFT_BITS;
                n.rx_busy = 1'b0;
            end else if (mode == spc_pkg::SPC_UART8) begin
                n.tx_sh = {2'h3, sfr_wdata_i, 1'b0};
                n.tx_left = spc_pkg::UART8_BITS;
            end else begin
                n.tx_sh = {1'b1, s.transmit_ninth_bit, sfr_wdata_i,
                           1'b0}; // R10
                n.tx_left = spc_pkg::UART9_BITS;
            end
        end else if (s.tx_busy && mode == spc_pkg::SPC_SHIFT) begin
            if (m0_end) begin
                n.tx_sh = {1'b1, s.tx_sh[10:1]};
                n.tx_left = s.tx_left - 4'h1;
                if (s.tx_left == 4'h1) begin
                    n.tx_busy = 1'b0;
                    n.transmit_done_flag = 1'b1;
                end
            end
        end else if (s.tx_busy && s16) begin
            n.tx_cnt = s.tx_cnt + 4'h1;
            if (s.tx_cnt == spc_pkg::OVERSAMPLE_LAST) begin
                n.tx_sh = {1'b1, s.tx_sh[10:1]};
                n.tx_left = s.tx_left - 4'h1;
                if (s.tx_left == 4'h2) begin
                    n.transmit_done_flag = 1'b1; // R12
                end
                if (s.tx_left == 4'h1) begin
                    n.tx_busy = 1'b0;
                end
            end
        end

        // receive engine
        if (mode == spc_pkg::SPC_SHIFT) begin
            if (!s.rx_busy) begin
                if (s.receive_enable && !s.receive_done_flag && !s.tx_busy
                    && !wr_buf) begin
                    n.rx_busy = 1'b1; // R15
                    n.rx_idx = spc_pkg::SHIFT_BITS;
                    n.phase = 3'h0;
                end
            end else if (m0_end) begin
                sh = {s.rxd_sync, s.rx_sh[8:1]};
                n.rx_sh = sh;
                n.rx_idx = s.rx_idx - 4'h1;
                if (s.rx_idx == 4'h1) begin
                    n.rx_busy = 1'b0;
                    n.rx_data = sh[8:1];
                    n.receive_done_flag = 1'b1; // R13
                end
            end
        end else if (!s.rx_busy) begin
            if (s.receive_enable && s.rxd_last && !s.rxd_sync) begin
                n.rx_busy = 1'b1; // R15
                n.rx_idx = 4'h0;
                n.rx_cnt = 4'h0;
            end
        end else if (s16) begin
            n.rx_cnt = s.rx_cnt + 4'h1;
            if (s.rx_cnt == spc_pkg::SAMPLE_POINT) begin
                bit_in = s.rxd_sync;
                n.rx_idx = s.rx_idx + 4'h1;
                if (s.rx_idx == 4'h0) begin
                    n.rx_busy = !bit_in; // false start drops the frame
                end else begin
                    if (s.rx_idx <= spc_pkg::UART8_LAST_IDX) begin
                        sh = {bit_in, s.rx_sh[8:1]};
                        n.rx_sh = sh;
                    end
                    if (s.rx_idx == last_idx) begin
                        n.rx_busy = 1'b0;
                        if (!bit_in) begin
                            n.framing_error_flag = 1'b1; // R1 R2 R4
                        end
                        if (!s.multiproc_or_clock_polarity || sh[8]) begin
                            n.receive_done_flag = 1'b1; // R13 R16
                            n.rx_data = sh[7:0];
                            n.receive_ninth_bit = sh[8]; // R11
                        end
                    end
                end
            end
        end

        // registered pins and request
        n.irq = n.transmit_done_flag || n.receive_done_flag; // R18
        if (mode == spc_pkg::SPC_SHIFT) begin
            n.txd = !(s.tx_busy || s.rx_busy) || (s.phase >= (per >> 1));
            n.txd = n.txd ^ s.multiproc_or_clock_polarity; // R9
        end else begin
            n.txd = s.tx_sh[0];
        end
        n.rxd_out = s.tx_sh[0];
        n.rxd_oe = (mode == spc_pkg::SPC_SHIFT) && s.tx_busy;

        // read data
        case (sfr_addr_i)
            spc_pkg::SERIAL_PORT_CONTROL_ADDR: begin
                n.rdata = {s.framing_error_view_select ? s.framing_error_flag
                                                       : s.mode_select_low,
                           s.mode_select_high, s.multiproc_or_clock_polarity,
                           s.receive_enable, s.transmit_ninth_bit,
                           s.receive_ninth_bit, s.transmit_done_flag,
                           s.receive_done_flag}; // R3 R5 R17
            end
            spc_pkg::POWER_CONTROL_ADDR: begin
                n.rdata = {s.baud_double_select, s.framing_error_view_select,
                           6'h00};
            end
            spc_pkg::SERIAL_DATA_ADDR: begin
                n.rdata = s.rx_data;
            end
            default: begin
                n.rdata = 8'h00;
            end
        endcase
    end

    // outputs
    assign sfr_rdata_o = s.rdata;
    assign txd_o = s.txd;
    assign rxd_o = s.rxd_out;
    assign rxd_oe_o = s.rxd_oe;
    assign serial_irq_o = s.irq;
endmodule

/* File: tb/spc_serial_port_asserts.sv */
// checker for the serial port control block
`timescale 1ns/1ps
module spc_serial_port_asserts (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic txd_o,
    input wire logic rxd_oe_o,
    input wire logic serial_irq_o
);
    logic view_t, mlo_t, mhi_t, dbl_t;
    wire logic is_sc = sfr_addr_i == spc_pkg::SERIAL_PORT_CONTROL_ADDR;
    wire logic is_pc = sfr_addr_i == spc_pkg::POWER_CONTROL_ADDR;
    wire logic is_sd = sfr_addr_i == spc_pkg::SERIAL_DATA_ADDR;
    // shadow of mode, view and divider bits from observed writes
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {dbl_t, view_t, mlo_t, mhi_t} <= 4'h0;
        end else if (sfr_wr_i && is_pc) begin
            {dbl_t, view_t} <= sfr_wdata_i[7:6];
        end else if (sfr_wr_i && is_sc) begin
            mhi_t <= sfr_wdata_i[6];
            if (!view_t) begin
                mlo_t <= sfr_wdata_i[7];
            end
        end
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // write, then one quiet cycle on the same address
    sequence s_wr(hit);
        sfr_wr_i && hit ##1 hit && !sfr_wr_i;
    endsequence
    sequence s_low8;
        !txd_o [*8];
    endsequence
    property p_unmapped;
        !$past(is_sc || is_pc || is_sd) |-> sfr_rdata_o == 8'h00;
    endproperty
    property p_power_control_register_low;
        $past(is_pc) |-> sfr_rdata_o[5:0] == 6'h00;
    endproperty
    property p_power_control_register_echo;
        s_wr(is_pc) |=> sfr_rdata_o[7:6] == $past(sfr_wdata_i[7:6], 2);
    endproperty
    property p_serial_port_control_echo;
        s_wr(is_sc) |=> sfr_rdata_o[6:3] == $past(sfr_wdata_i[6:3], 2);
    endproperty
    property p_bit7;
        s_wr(is_sc) |=> sfr_rdata_o[7] == $past(sfr_wdata_i[7], 2);
    endproperty
    property p_irq;
        $past(is_sc) && !$past(sfr_wr_i) && sfr_rdata_o[1:0] != 2'h0
            |-> ##[0:2] serial_irq_o;
    endproperty
    property p_oe;
        rxd_oe_o |-> !mlo_t && !mhi_t;
    endproperty
    property p_start;
        $fell(txd_o) && mlo_t && !mhi_t && dbl_t |-> s_low8 ##1 s_low8;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    a_power_control_register_low: assert property (p_power_control_register_low)
        else $error("power control low bits not zero");
    a_power_control_register_echo: assert property (p_power_control_register_echo)
        else $error("power control bits not written");
    a_serial_port_control_echo: assert property (p_serial_port_control_echo)
        else $error("control bits not written");
    a_bit7: assert property (p_bit7)
        else $error("control bit 7 not written");
    a_irq: assert property (p_irq)
        else $error("irq low with done flag set");
    a_oe: assert property (p_oe)
        else $error("rxd driven outside shift mode");
    a_start: assert property (p_start)
        else $error("mode 2 bit shorter than 16 clocks");
endmodule
bind spc_serial_port spc_serial_port_asserts u_spc_serial_port_asserts (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .txd_o(txd_o), .rxd_oe_o(rxd_oe_o),
    .serial_irq_o(serial_irq_o)
);

/* File: tb/spc_peer_model.sv */
// serial peer: sends frames to the receiver, captures sent frames
`timescale 1ns/1ps
module spc_peer_model (
    input wire logic clk_i,
    input wire logic txd_i,
    output logic line_o
);
    // line marks high between frames
    initial line_o = 1'b1;
    // start, data lsb first, ninth bit, stop
    task automatic send(input logic [7:0] d, input logic nb,
            input logic st, input int bp);
        logic [10:0] f;
        f = {st, nb, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge clk_i);
            #1 line_o = f[i];
            repeat (bp - 1) @(posedge clk_i);
        end
        @(posedge clk_i);
        #1 line_o = 1'b1;
    endtask
    // mid-bit sampling after the start edge
    task automatic get(output logic [7:0] d, output logic [1:0] tl,
            input int bp);
        logic [9:0] f;
        while (txd_i !== 1'b0) @(posedge clk_i);
        repeat (bp / 2) @(posedge clk_i);
        for (int i = 0; i < 10; i++) begin
            repeat (bp) @(posedge clk_i);
            f[i] = txd_i;
        end
        d = f[7:0];
        tl = f[9:8];
    endtask
endmodule

/* File: tb/spc_serial_port_tb.sv */
// self-checking bench for the serial port control block
`timescale 1ns/1ps
module spc_serial_port_tb;
    localparam logic [7:0] SC = spc_pkg::SERIAL_PORT_CONTROL_ADDR;
    localparam logic [7:0] PC = spc_pkg::POWER_CONTROL_ADDR;
    localparam logic [7:0] SD = spc_pkg::SERIAL_DATA_ADDR;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] sfr_addr_i = 8'h00;
    logic sfr_wr_i = 1'b0;
    logic [7:0] sfr_wdata_i = 8'h00;
    logic [7:0] sfr_rdata_o;
    logic txd_o, rxd_o, rxd_oe_o, serial_irq_o, peer_line;
    logic tmr1 = 1'b0;
    wire logic rxd_i = rxd_oe_o ? rxd_o : peer_line;
    int failures = 0;
    int num_checks = 0;
    always #10 clk_sys_i = ~clk_sys_i;
    spc_serial_port u_spc_serial_port (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i),
        .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
        .sfr_rdata_o(sfr_rdata_o), .timer1_ovf_i(tmr1), .timer2_ovf_i(1'b0),
        .baud_from_timer2_i(1'b0), .compat_mode_i(1'b0), .txd_o(txd_o),
        .rxd_i(rxd_i), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o),
        .serial_irq_o(serial_irq_o)
    );
    spc_peer_model u_spc_peer_model (
        .clk_i(clk_sys_i), .txd_i(txd_o), .line_o(peer_line)
    );
    // byte compare
    task automatic chk(input string n, input logic [7:0] e,
            input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    // one-cycle register write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        #1 sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1'b1;
        @(posedge clk_sys_i);
        #1 sfr_wr_i = 1'b0;
    endtask
    // register read and compare
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys_i);
        #1 sfr_addr_i = a;
        repeat (2) @(posedge clk_sys_i);
        #1 chk("register", e, sfr_rdata_o);
    endtask
    task automatic t_reset();
        rchk(SC, 8'h00);
        rchk(PC, 8'h00);
        rchk(8'h55, 8'h00);
        chk("irq", 8'h00, {7'h0, serial_irq_o});
    endtask
    task automatic t_layout();
        wr(SC, 8'hF8);
        rchk(SC, 8'hF8);
        wr(PC, 8'hC0);
        rchk(PC, 8'hC0);
        rchk(SC, 8'h78);
        wr(PC, 8'h80);
        rchk(SC, 8'hF8);
    endtask
    task automatic t_frame_error();
        wr(SC, 8'h90);
        u_spc_peer_model.send(8'h5A, 1'b1, 1'b0, 16);
        wr(PC, 8'hC0);
        rchk(SC, 8'h95);
        chk("irq", 8'h01, {7'h0, serial_irq_o});
        wr(SC, 8'h10);
        rchk(SC, 8'h10);
        wr(PC, 8'h80);
        rchk(SC, 8'h90);
        u_spc_peer_model.send(8'h3C, 1'b1, 1'b0, 16);
        u_spc_peer_model.send(8'hA5, 1'b0, 1'b1, 16);
        wr(PC, 8'hC0);
        rchk(SC, 8'h91);
        rchk(SD, 8'hA5);
        wr(SC, 8'h10);
        wr(PC, 8'h80);
    endtask
    task automatic t_multiproc();
        wr(SC, 8'hB0);
        u_spc_peer_model.send(8'h77, 1'b0, 1'b1, 16);
        rchk(SC, 8'hB0);
        chk("irq", 8'h00, {7'h0, serial_irq_o});
        u_spc_peer_model.send(8'h4E, 1'b1, 1'b1, 16);
        rchk(SC, 8'hB5);
        rchk(SD, 8'h4E);
        wr(SC, 8'hB0);
        rchk(SC, 8'hB0);
        chk("irq", 8'h00, {7'h0, serial_irq_o});
    endtask
    // 8-bit uart on a timer tick every clock: stop bit into rx ninth bit
    task automatic t_mode1();
        @(posedge clk_sys_i);
        #1 tmr1 = 1'b1;
        wr(SC, 8'h50);
        u_spc_peer_model.send(8'h96, 1'b1, 1'b1, 16);
        rchk(SC, 8'h55);
        rchk(SD, 8'h96);
        u_spc_peer_model.send(8'h69, 1'b0, 1'b1, 16);
        wr(PC, 8'hC0);
        rchk(SC, 8'hD1);
        wr(SC, 8'h50);
        wr(PC, 8'h80);
        @(posedge clk_sys_i);
        #1 tmr1 = 1'b0;
    endtask
    // both divider settings, both ninth bit values
    task automatic t_transmit();
        logic [7:0] d;
        logic [1:0] tl;
        for (int i = 0; i < 2; i++) begin
            wr(PC, i[0] ? 8'h80 : 8'h00);
            wr(SC, {4'h8, i[0], 3'h0});
            fork
                u_spc_peer_model.get(d, tl, i[0] ? 16 : 32);
                wr(SD, 8'hC3 + i[7:0]);
            join
            chk("data", 8'hC3 + i[7:0], d);
            chk("tail", {6'h0, 1'b1, i[0]}, {6'h0, tl});
            rchk(SC, {4'h8, i[0], 3'h2});
        end
    endtask
    task automatic t_shift();
        logic [7:0] d;
        wr(SC, 8'h00);
        repeat (2) @(posedge clk_sys_i);
        #1 chk("clock idle", 8'h01, {7'h0, txd_o});
        fork
            wr(SD, 8'hA5);
            for (int i = 0; i < 8; i++) begin
                @(posedge txd_o);
                #1 d[i] = rxd_o;
                if (i == 0) chk("shift oe", 8'h01, {7'h0, rxd_oe_o});
            end
        join
        chk("shift data", 8'hA5, d);
        repeat (60) @(posedge clk_sys_i);
        rchk(SC, 8'h02);
        chk("shift oe", 8'h00, {7'h0, rxd_oe_o});
        wr(SC, 8'h20);
        repeat (2) @(posedge clk_sys_i);
        chk("clock idle", 8'h00, {7'h0, txd_o});
    endtask
    task automatic tally_and_finish();
        if (failures == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // reset, then the scenarios in turn
    initial begin
        repeat (20) @(posedge clk_sys_i);
        #1 rst_n_i = 1'b1;
        repeat (3) @(posedge clk_sys_i);
        t_reset();
        t_layout();
        t_frame_error();
        t_multiproc();
        t_mode1();
        t_transmit();
        t_shift();
        tally_and_finish();
    end
    // hang guard, several times the expected run
    initial begin
        #400000;
        failures++;
        tally_and_finish();
    end
endmodule
